//--- core/nio_pkg.sv
// Purpose: constants for the narrow io ports group (single, octal input, quad ports)
// Assumes: classic wishbone, 32-bit data, register index = byte address / 4
// Notes:   register data sits in the low byte, upper bits read zero
//
// Behaviour
// - single pin drives when its direction bit is 1 and gpio mode is on, input otherwise.
// - both direction registers read back as all ones.
// - single direction resets to 80h on reset and hw standby; kept in sw standby.
// - in sw standby a driving pin keeps its output level.
// - single port read with direction 1 returns the latch bit.
// - single data bit 7 reads 1; bits 6,2,1 read latch if direction 1, else 1.
// - single data bits 5..3 store writes; read latch if direction 1, else undefined.
// - single data resets to 80h on reset and hw standby; kept in sw standby.
// - gpio only when all wait enables set and wait mode high 0; else wait input.
// - octal port read always returns its current pin levels.
// - quad pins are gpio and feed the four interrupt request inputs.
// - lowest quad pin drives when its direction bit is 1.
// - quad direction resets to E0h on reset and hw standby; kept in sw standby.
// - quad read bits 3..0 return latch where direction 1, pin level where 0.
// - quad data bits 7..5 read 1; bit 4 reads latch if direction 1, else 1.
// - quad data resets to E0h on reset and hw standby; kept in sw standby.

package nio_pkg;

    // ----------------------------------------
    // bus geometry
    // ----------------------------------------
    localparam int          ADR_W = 18;
    localparam int          IDX_W = 16;

    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam logic [15:0] IDX_SINGLE_DIR = 16'hFFC9;
    localparam logic [15:0] IDX_SINGLE_DAT = 16'hFFCB;
    localparam logic [15:0] IDX_QUAD_DIR   = 16'hFFCD;
    localparam logic [15:0] IDX_OCTAL_DAT  = 16'hFFCE;
    localparam logic [15:0] IDX_QUAD_DAT   = 16'hFFCF;

    // ----------------------------------------
    // reset values and fixed fields
    // ----------------------------------------
    localparam logic [7:0]  RST_SINGLE     = 8'h80;
    localparam logic [7:0]  RST_QUAD       = 8'hE0;
    localparam logic [7:0]  DIR_READ_VAL   = 8'hFF;
    localparam logic [7:0]  WAIT_ALL_EN    = 8'hFF;
    localparam logic [7:0]  SINGLE_FIX_ONE = 8'h80;
    localparam logic [7:0]  QUAD_FIX_ONE   = 8'hE0;
    localparam logic [7:0]  SINGLE_ONE_BITS = 8'h46;
    localparam logic [7:0]  SINGLE_UNDEF_BITS = 8'h38;

endpackage : nio_pkg

//--- core/nio_ports.sv
// Purpose: register file and pin logic of the single, octal input and quad ports
// Assumes: pins come from outside the clock domain; wait controller bits and standby
//          levels come from logic on ref_clk
// Notes:   one wait cycle per bus access, ack and read data both from flops

`timescale 1ns/10ps

module nio_ports
(
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    // wishbone slave
    input  wire logic                         cyc_i,
    input  wire logic                         stb_i,
    input  wire logic                         we_i,
    input  wire logic [nio_pkg::ADR_W-1:0]    adr_i,
    input  wire logic [3:0]                   sel_i,
    input  wire logic [31:0]                  dat_i,
    output logic      [31:0]                  dat_o,
    output logic                              ack_o,
    // standby and wait controller state
    input  wire logic                         hw_standby,
    input  wire logic                         sw_standby,
    input  wire logic [7:0]                   wait_area_enable_bits,
    input  wire logic                         wait_mode_select_high,
    // single pin port
    input  wire logic                         single_pin_i,
    output logic                              single_pin_o,
    output logic                              single_pin_oe,
    output logic                              wait_n_o,
    // octal input port
    input  wire logic [7:0]                   octal_pin_i,
    // quad port
    input  wire logic [3:0]                   quad_pin_i,
    output logic      [3:0]                   quad_pin_o,
    output logic      [3:0]                   quad_pin_oe,
    output logic      [3:0]                   irq_n_o
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [7:0]              dir_s_q;
    logic [7:0]              dat_s_q;
    logic [7:0]              dir_q_q;
    logic [7:0]              dat_q_q;
    logic [1:0]              single_sync_q;
    logic [7:0]              octal_meta_q;
    logic [7:0]              octal_sync_q;
    logic [3:0]              quad_meta_q;
    logic [3:0]              quad_sync_q;
    logic                    ack_q;
    logic [31:0]             dat_o_q;
    logic [31:0]             rd_d;
    logic [nio_pkg::IDX_W-1:0] idx;
    logic                    req;
    logic                    wr;
    logic                    gpio_mode;

    assign idx = adr_i[nio_pkg::ADR_W-1:2];
    assign req = cyc_i && stb_i && !ack_q;
    // writes held off in sw standby so the latches really retain
    assign wr  = req && we_i && sel_i[0] && !sw_standby;

    assign gpio_mode = (wait_area_enable_bits == nio_pkg::WAIT_ALL_EN) && !wait_mode_select_high;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        single_sync_q <= {single_sync_q[0], single_pin_i};
        octal_meta_q  <= octal_pin_i;
        octal_sync_q  <= octal_meta_q;
        quad_meta_q   <= quad_pin_i;
        quad_sync_q   <= quad_meta_q;
    end

    // ----------------------------------------
    // single port registers
    // ----------------------------------------
    // reset and hw standby load
    always_ff @(posedge ref_clk)
    begin
        if (rst || hw_standby)
            dir_s_q <= nio_pkg::RST_SINGLE;
        else if (wr && idx == nio_pkg::IDX_SINGLE_DIR)
            dir_s_q <= dat_i[7:0] | nio_pkg::SINGLE_FIX_ONE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || hw_standby)
            dat_s_q <= nio_pkg::RST_SINGLE;
        else if (wr && idx == nio_pkg::IDX_SINGLE_DAT)
            dat_s_q <= dat_i[7:0] | nio_pkg::SINGLE_FIX_ONE;
    end

    // ----------------------------------------
    // quad port registers
    // ----------------------------------------
    // reset and hw standby load
    always_ff @(posedge ref_clk)
    begin
        if (rst || hw_standby)
            dir_q_q <= nio_pkg::RST_QUAD;
        else if (wr && idx == nio_pkg::IDX_QUAD_DIR)
            dir_q_q <= dat_i[7:0] | nio_pkg::QUAD_FIX_ONE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || hw_standby)
            dat_q_q <= nio_pkg::RST_QUAD;
        else if (wr && idx == nio_pkg::IDX_QUAD_DAT)
            dat_q_q <= dat_i[7:0] | nio_pkg::QUAD_FIX_ONE;
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (idx)
            nio_pkg::IDX_SINGLE_DIR,
            nio_pkg::IDX_QUAD_DIR:
                rd_d[7:0] = nio_pkg::DIR_READ_VAL;
            nio_pkg::IDX_SINGLE_DAT:
            begin
                rd_d[7:0] = nio_pkg::SINGLE_FIX_ONE
                          | (nio_pkg::SINGLE_ONE_BITS & (dat_s_q | ~dir_s_q));
                rd_d[5:3] = dat_s_q[5:3];
                rd_d[0]   = dir_s_q[0] ? dat_s_q[0] : single_sync_q[1];
            end
            nio_pkg::IDX_OCTAL_DAT:
                rd_d[7:0] = octal_sync_q;
            nio_pkg::IDX_QUAD_DAT:
            begin
                rd_d[7:5] = nio_pkg::QUAD_FIX_ONE[7:5];
                rd_d[4]   = dir_q_q[4] ? dat_q_q[4] : 1'b1;
                rd_d[3:0] = (dat_q_q[3:0] & dir_q_q[3:0]) | (quad_sync_q & ~dir_q_q[3:0]);
            end
            default:
                rd_d = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            dat_o_q <= 32'h0000_0000;
        else if (req && !we_i)
            dat_o_q <= rd_d;
    end

    assign ack_o = ack_q;
    assign dat_o = dat_o_q;

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // single pin drive
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            single_pin_oe <= 1'b0;
            single_pin_o  <= 1'b0;
            wait_n_o      <= 1'b1;
        end
        else
        begin
            single_pin_oe <= gpio_mode && dir_s_q[0];
            // latch held, so level held in sw standby
            single_pin_o  <= dat_s_q[0];
            // wait input passes only outside gpio mode
            wait_n_o      <= gpio_mode ? 1'b1 : single_sync_q[1];
        end
    end

    // only the lowest quad pin can drive
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            quad_pin_oe <= 4'h0;
            quad_pin_o  <= 4'h0;
        end
        else
        begin
            // upper pins never driven even if misprogrammed
            quad_pin_oe <= {3'b000, dir_q_q[0]};
            quad_pin_o  <= {3'b000, dat_q_q[0]};
        end
    end

    // interrupt requests follow the quad pins in every mode
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irq_n_o <= 4'hF;
        else
            irq_n_o <= quad_sync_q;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // bus answer checks
    // ----------------------------------------
    // answer one cycle after the take
    a_ack_next: assert property (req |=> ack_o)
        else $error("request not answered");

    // ack is a pulse
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");

    // upper lanes unused
    a_rd_upper_zero: assert property (dat_o[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");

    a_dir_read_ones: assert property (
        req && !we_i && (idx == nio_pkg::IDX_SINGLE_DIR || idx == nio_pkg::IDX_QUAD_DIR)
        |=> ack_o && dat_o[7:0] == 8'hFF) else $error("direction read not all ones");

    // ----------------------------------------
    // single port and sw standby checks
    // ----------------------------------------
    // enable follows direction in gpio mode
    a_single_drive: assert property (1'b1 |=> single_pin_oe == $past(gpio_mode && dir_s_q[0]))
        else $error("single pin enable wrong");

    a_single_level: assert property (1'b1 |=> single_pin_o == $past(dat_s_q[0]))
        else $error("single pin level wrong");

    a_hw_stby_single: assert property (hw_standby |=> dir_s_q == 8'h80 && dat_s_q == 8'h80)
        else $error("single regs not reset in hw standby");

    a_single_wr_land: assert property (wr && idx == nio_pkg::IDX_SINGLE_DAT && !hw_standby
        |=> dat_s_q == ($past(dat_i[7:0]) | nio_pkg::SINGLE_FIX_ONE))
        else $error("single data write lost");

    a_single_rd_latch: assert property (req && !we_i && idx == nio_pkg::IDX_SINGLE_DAT && dir_s_q[0]
        |=> dat_o[0] == $past(dat_s_q[0]) && dat_o[7]) else $error("single read not latch");

    a_single_rd_pin: assert property (req && !we_i && idx == nio_pkg::IDX_SINGLE_DAT && !dir_s_q[0]
        |=> dat_o[0] == $past(single_sync_q[1])) else $error("single read not pin");

    a_single_fix_bits: assert property (req && !we_i && idx == nio_pkg::IDX_SINGLE_DAT
        |=> dat_o[7] && (dat_o[6] || $past(dir_s_q[6])) && (dat_o[2] || $past(dir_s_q[2]))
            && (dat_o[1] || $past(dir_s_q[1])))
        else $error("single fixed bits wrong");

    a_single_undef: assert property (req && !we_i && idx == nio_pkg::IDX_SINGLE_DAT
        |=> (dat_o[7:0] & nio_pkg::SINGLE_UNDEF_BITS) == ($past(dat_s_q) & nio_pkg::SINGLE_UNDEF_BITS))
        else $error("single free bits wrong");

    a_wait_release: assert property (!gpio_mode |=> !single_pin_oe && wait_n_o == $past(single_sync_q[1]))
        else $error("wait function wrong");

    a_wait_idle: assert property (gpio_mode |=> wait_n_o)
        else $error("wait not idle in gpio mode");

    a_sw_stby_regs: assert property (sw_standby && !hw_standby
        |=> $stable(dir_s_q) && $stable(dat_s_q) && $stable(dir_q_q) && $stable(dat_q_q))
        else $error("registers moved in sw standby");

    a_sw_stby_hold: assert property (sw_standby && !hw_standby && quad_pin_oe[0]
        |=> quad_pin_oe[0] && $stable(quad_pin_o[0]) && $stable(dat_s_q))
        else $error("standby output moved");

    // ----------------------------------------
    // quad and octal port checks
    // ----------------------------------------
    // hw standby load
    a_quad_stby_load: assert property (hw_standby |=> dir_q_q == 8'hE0 && dat_q_q == 8'hE0)
        else $error("quad regs not reset in hw standby");

    a_quad_wr_land: assert property (wr && idx == nio_pkg::IDX_QUAD_DAT && !hw_standby
        |=> dat_q_q == ($past(dat_i[7:0]) | nio_pkg::QUAD_FIX_ONE))
        else $error("quad data write lost");

    a_quad_fix_bits: assert property (req && !we_i && idx == nio_pkg::IDX_QUAD_DAT
        |=> dat_o[7:5] == 3'b111 && (dat_o[4] || $past(dir_q_q[4]))) else $error("quad fixed bits wrong");

    a_quad_rd_mix: assert property (req && !we_i && idx == nio_pkg::IDX_QUAD_DAT
        |=> dat_o[7:0] == {3'b111, $past(dir_q_q[4]) ? $past(dat_q_q[4]) : 1'b1,
                           ($past(dat_q_q[3:0]) & $past(dir_q_q[3:0])) | ($past(quad_sync_q) & ~$past(dir_q_q[3:0]))})
        else $error("quad read mix wrong");

    a_quad_upper_in: assert property (quad_pin_oe[3:1] == 3'b000)
        else $error("quad upper pin driven");

    a_quad_low_drive: assert property (1'b1 |=> quad_pin_oe[0] == $past(dir_q_q[0]) && quad_pin_o[0] == $past(dat_q_q[0]))
        else $error("quad low pin drive wrong");

    a_irq_follow: assert property (1'b1 |=> irq_n_o == $past(quad_sync_q))
        else $error("irq not following pins");

    a_octal_read: assert property (req && !we_i && idx == nio_pkg::IDX_OCTAL_DAT
        |=> dat_o[7:0] == $past(octal_sync_q)) else $error("octal read not pins");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_single_out: cover property (gpio_mode && dir_s_q[0] ##1 single_pin_oe);
    c_wait_mode:  cover property (!gpio_mode ##1 !wait_n_o);
    c_quad_write: cover property (wr && idx == nio_pkg::IDX_QUAD_DAT ##1 ack_o);
    c_sw_standby: cover property (sw_standby && single_pin_oe);
    c_hw_standby: cover property (hw_standby ##1 !hw_standby);

endmodule // nio_ports

//--- sim/nio_pins_model.sv
// Purpose: far side of the ports: board pins
// Assumes: undriven pins follow board levels set by the bench
// Notes:   a driven pin reads back its driven level
`timescale 1ns/10ps

module nio_pins_model
(
    // from the ports
    input  wire logic       single_pin_o,
    input  wire logic       single_pin_oe,
    input  wire logic [3:0] quad_pin_o,
    input  wire logic [3:0] quad_pin_oe,
    // board levels
    input  wire logic       single_ext,
    input  wire logic [3:0] quad_ext,
    // resolved pins
    output logic            single_pin_i,
    output logic [3:0]      quad_pin_i
);
    assign single_pin_i = single_pin_oe ? single_pin_o : single_ext;
    assign quad_pin_i   = (quad_pin_oe & quad_pin_o) | (~quad_pin_oe & quad_ext);
endmodule // nio_pins_model

//--- sim/nio_ports_test.sv
// Purpose: self-checking bench of the narrow io ports group
// Assumes: classic wishbone master, one access at a time
// Notes:   pins resolved by nio_pins_model
`timescale 1ns/10ps

module nio_ports_test;
    // ----
    // signals
    // ----
    localparam logic [15:0] SDIR = nio_pkg::IDX_SINGLE_DIR;
    localparam logic [15:0] SDAT = nio_pkg::IDX_SINGLE_DAT;
    localparam logic [15:0] QDIR = nio_pkg::IDX_QUAD_DIR;
    localparam logic [15:0] QDAT = nio_pkg::IDX_QUAD_DAT;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [17:0] adr = 18'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o, s_i, s_o, s_oe, wait_n_o;
    logic        hws = 1'b0, sws = 1'b0, wms = 1'b0, s_ext = 1'b0;
    logic [7:0]  wen = 8'hFF, oct = 8'h00;
    logic [3:0]  q_ext = 4'hA, q_i, q_o, q_oe, irq_n_o;
    int          num_errors = 0;
    int          total_checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    nio_ports nio_ports_inst
    (
        .ref_clk(ref_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .hw_standby(hws),
        .sw_standby(sws), .wait_area_enable_bits(wen), .wait_mode_select_high(wms),
        .single_pin_i(s_i), .single_pin_o(s_o), .single_pin_oe(s_oe), .wait_n_o(wait_n_o),
        .octal_pin_i(oct), .quad_pin_i(q_i), .quad_pin_o(q_o), .quad_pin_oe(q_oe), .irq_n_o(irq_n_o)
    );

    nio_pins_model nio_pins_model_inst
    (
        .single_pin_o(s_o), .single_pin_oe(s_oe), .quad_pin_o(q_o), .quad_pin_oe(q_oe),
        .single_ext(s_ext), .quad_ext(q_ext), .single_pin_i(s_i), .quad_pin_i(q_i)
    );

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until ack is sampled high
    task automatic wb(input logic w, input logic [15:0] ix, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {ix, 2'b00};
        dat <= {24'h000000, d};
        @(posedge ref_clk);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20)
        begin
            num_errors++;
            give_verdict();
        end
        r = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] ix, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, ix, d, r);
    endtask

    task automatic rd(input string nm, input logic [15:0] ix, input logic [7:0] e);
        logic [7:0] r;
        wb(1'b0, ix, 8'h00, r);
        chk(nm, e, r);
    endtask

    // pins pass two sync flops, outputs one flop
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end

    // ----
    // tests
    // ----
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd("single_dir", SDIR, 8'hFF);
        rd("quad_dir", QDIR, 8'hFF);
        rd("single_dat", SDAT, 8'hC6);
        rd("quad_dat", QDAT, 8'hFA);
        rd("unmapped", 16'hFFC0, 8'h00);
        chk("single_oe", 8'h00, {7'h00, s_oe});
        $display("test reset done");
        wr(SDAT, 8'h35);
        wr(SDIR, 8'h47);
        rd("single_out", SDAT, 8'hB5);
        settle();
        chk("single_drive", 8'h03, {6'h00, s_oe, s_o});
        chk("wait_gpio", 8'h01, {7'h00, wait_n_o});
        @(posedge ref_clk);
        s_ext <= 1'b1;
        wr(SDIR, 8'h00);
        settle();
        chk("single_free", 8'h00, {7'h00, s_oe});
        rd("single_in", SDAT, 8'hF7);
        $display("test single done");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge ref_clk);
            wms <= (k == 0);
            wen <= (k == 0) ? 8'hFF : 8'hFE;
            s_ext <= 1'b0;
            settle();
            chk("wait_low", 8'h00, {7'h00, wait_n_o});
            @(posedge ref_clk);
            s_ext <= 1'b1;
            settle();
            chk("wait_high", 8'h01, {7'h00, wait_n_o});
        end
        @(posedge ref_clk);
        wms <= 1'b0;
        wen <= 8'hFF;
        $display("test wait done");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge ref_clk);
            oct <= 8'h5A ^ {8{k[0]}};
            settle();
            rd("octal", nio_pkg::IDX_OCTAL_DAT, 8'h5A ^ {8{k[0]}});
        end
        $display("test octal done");
        // only lowest quad pin made output
        wr(QDIR, 8'h11);
        wr(QDAT, 8'h1F);
        rd("quad_out", QDAT, 8'hFB);
        settle();
        chk("quad_drive", 8'h11, {q_oe, q_o});
        chk("quad_irq", 8'h0B, {4'h0, irq_n_o});
        wr(QDAT, 8'h0E);
        rd("quad_low", QDAT, 8'hEA);
        $display("test quad done");
        wr(SDIR, 8'h01);
        wr(SDAT, 8'h01);
        @(posedge ref_clk);
        sws <= 1'b1;
        wr(SDIR, 8'h00);
        wr(SDAT, 8'h00);
        wr(QDIR, 8'h00);
        settle();
        chk("sw_pins", 8'h31, {2'b00, s_oe, s_o, q_oe});
        rd("sw_single", SDAT, 8'hC7);
        rd("sw_quad", QDAT, 8'hEA);
        @(posedge ref_clk);
        sws <= 1'b0;
        hws <= 1'b1;
        repeat (2) @(posedge ref_clk);
        hws <= 1'b0;
        settle();
        chk("hw_pins", 8'h00, {3'h0, s_oe, q_oe});
        rd("hw_single", SDAT, 8'hC7);
        rd("hw_quad", QDAT, 8'hFA);
        $display("test standby done");
        give_verdict();
    end
endmodule // nio_ports_test
